// file: hw/embus_pkg.sv
/*
  Package for the external memory bus interface: configuration decode,
  bus request carrier, cycle timing constants.
  Assumes one core clock domain and one chip reset.
*/
package embus_pkg;

   // -----------------------------------------------------------------
   // Range configuration modes
   // -----------------------------------------------------------------
   // Range config encoding: 2'h3 = 64K (read strobe pin, no A16/A17),
   // 2'h2 = 128K (A16 on read pin), 2'h1 = 128K (A16 on dedicated pin),
   // 2'h0 = 256K (A16 and A17 driven).
   localparam logic [1:0] RANGE_64K       = 2'h3;
   localparam logic [1:0] RANGE_128K_RDPIN = 2'h2;
   localparam logic [1:0] RANGE_128K      = 2'h1;
   localparam logic [1:0] RANGE_256K      = 2'h0;

   // -----------------------------------------------------------------
   // Timing and reset values
   // -----------------------------------------------------------------
   localparam int unsigned CLK_HZ        = 20_000_000;
   localparam int unsigned ALE_NS        = 50;
   localparam int unsigned ALE_CYC       = (ALE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam logic [2:0]  ALE_CYC_W     = 3'(ALE_CYC);
   localparam logic [17:0] ADDR_RST      = 18'h00000;
   localparam logic [7:0]  DATA_RST      = 8'h00;
   localparam logic [17:0] ROM_TOP_RST   = 18'h07FFF;

   typedef struct packed {
      logic        is_code;   // Program fetch rather than data access
      logic        is_write;
      logic [17:0] addr;
      logic [7:0]  wdata;
   } embus_req_s;

   typedef enum logic [2:0] {
      EMB_IDLE,
      EMB_ALE,
      EMB_ADDR_HOLD,
      EMB_STROBE,
      EMB_DONE
   } embus_state_e;

endpackage

// file: hw/embus_ctrl.sv
/*
  External memory bus controller: multiplexed address/data low byte,
  upper address byte, two extra address bits, latch strobe, read, write
  and program strobes, asynchronous wait, external access strap.
  Assumes a core that issues one request at a time and holds it until done.
*/
// What this block does
// - The top address pin carries address bit 17 only when the range bits select 256K mode.
// - The second-top address pin carries address bit 16 in the 256K mode and in the 128K mode with a dedicated pin.
// - Address bits 15 to 8 sit on the upper address byte during external cycles.
// - Low address and data share one bidirectional byte, address first, then data.
// - The latch strobe pulses at the start of each cycle with valid low and high address.
// - A low wait input stretches the strobe phase until it returns high.
// - With the strap low every code fetch goes off-chip.
// - With the strap high code fetches inside the on-chip range stay on-chip.
// - The strap is caught once after reset release and held until the next reset.
// - The program strobe covers the address range chosen by the range bits.
// - The read strobe pin is either the data read strobe or address bit 16.
module embus_ctrl #(
   parameter logic [17:0] ROM_TOP = embus_pkg::ROM_TOP_RST
) (
   input  wire logic                  sys_clk,
   input  wire logic                  rst_n,
   input  wire logic [1:0]            range_cfg,
   input  wire logic                  req_valid,
   input  wire embus_pkg::embus_req_s req,
   output logic                       req_done,
   output logic                       req_onchip,
   output logic [7:0]                 rdata,
   output logic [7:0]                 muxed_addr_data_low_o,
   output logic                       muxed_addr_data_low_oe,
   input  wire logic [7:0]            muxed_addr_data_low_i,
   output logic [7:0]                 upper_address_byte,
   output logic                       top_address_bit,
   output logic                       second_top_address_bit,
   output logic                       rd_or_a16_pin,
   output logic                       write_strobe_n,
   output logic                       program_store_strobe_n,
   output logic                       addr_latch_strobe,
   input  wire logic                  async_wait_n,
   input  wire logic                  external_access_select_n
);

   // Code range must fit the 18-bit external space
   if (ROM_TOP > 18'h3FFFF) begin : g_rom_top_bad
      $error("ROM_TOP out of range");
   end

   // ----------------------------------------------------------------
   // Pin synchronisers and strap capture
   // ----------------------------------------------------------------
   logic [1:0] wait_sync;
   logic [1:0] strap_sync;
   logic       wait_low;
   logic       strap_hi;
   logic       strap_taken;
   logic [1:0] strap_fill;
   logic [1:0] next_wait_sync;
   logic [1:0] next_strap_sync;
   logic       next_strap_hi;
   logic       next_strap_taken;
   logic [1:0] next_strap_fill;

   always_comb begin
      next_wait_sync   = {wait_sync[0], async_wait_n};
      next_strap_sync  = {strap_sync[0], external_access_select_n};
      next_strap_fill  = {strap_fill[0], 1'b1};
      next_strap_hi    = strap_hi;
      next_strap_taken = strap_taken;
      // Capture strap once
      // Waits until the synchroniser holds the pin, not its reset value
      if (!strap_taken && strap_fill[1]) begin
         next_strap_hi    = strap_sync[1];
         next_strap_taken = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_sync   <= 2'h3;
         strap_sync  <= 2'h0;
         strap_hi    <= 1'b0;
         strap_taken <= 1'b0;
         strap_fill  <= 2'h0;
      end else begin
         wait_sync   <= next_wait_sync;
         strap_sync  <= next_strap_sync;
         strap_hi    <= next_strap_hi;
         strap_taken <= next_strap_taken;
         strap_fill  <= next_strap_fill;
      end
   end

   assign wait_low = ~wait_sync[1];

   // ----------------------------------------------------------------
   // Range decode
   // ----------------------------------------------------------------
   // Static range decode
   logic a17_on;
   logic a16_dedicated;
   logic a16_on_rdpin;
   assign a17_on        = (range_cfg == embus_pkg::RANGE_256K);
   assign a16_dedicated = (range_cfg == embus_pkg::RANGE_256K) ||
                          (range_cfg == embus_pkg::RANGE_128K);
   assign a16_on_rdpin  = (range_cfg == embus_pkg::RANGE_128K_RDPIN);

   logic onchip_hit;
   assign onchip_hit = req.is_code && strap_hi && (req.addr <= ROM_TOP);

   // ----------------------------------------------------------------
   // Bus cycle sequencer
   // ----------------------------------------------------------------
   embus_pkg::embus_state_e state;
   embus_pkg::embus_state_e next_state;
   embus_pkg::embus_req_s   cur;
   embus_pkg::embus_req_s   next_cur;
   logic [2:0]              cnt;
   logic [2:0]              next_cnt;
   logic [7:0]              next_rdata;
   logic                    next_done;
   logic                    next_onchip;

   always_comb begin
      next_state  = state;
      next_cur    = cur;
      next_cnt    = cnt;
      next_rdata  = rdata;
      next_done   = 1'b0;
      next_onchip = 1'b0;
      unique case (state)
         embus_pkg::EMB_IDLE: begin
            if (req_valid && strap_taken) begin
               if (onchip_hit) begin
                  next_done   = 1'b1;
                  next_onchip = 1'b1;
                  next_state  = embus_pkg::EMB_DONE;
               end else begin
                  next_cur   = req;
                  next_cnt   = embus_pkg::ALE_CYC_W;
                  next_state = embus_pkg::EMB_ALE;
               end
            end
         end
         embus_pkg::EMB_ALE: begin
            next_cnt = cnt - 3'h1;
            if (cnt == 3'h1) begin
               next_state = embus_pkg::EMB_ADDR_HOLD;
            end
         end
         embus_pkg::EMB_ADDR_HOLD: begin
            next_state = embus_pkg::EMB_STROBE;
         end
         embus_pkg::EMB_STROBE: begin
            if (!wait_low) begin
               next_rdata = muxed_addr_data_low_i;
               next_done  = 1'b1;
               next_state = embus_pkg::EMB_DONE;
            end
         end
         embus_pkg::EMB_DONE: begin
            next_state = embus_pkg::EMB_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state      <= embus_pkg::EMB_IDLE;
         cur        <= '0;
         cnt        <= 3'h0;
         rdata      <= embus_pkg::DATA_RST;
         req_done   <= 1'b0;
         req_onchip <= 1'b0;
      end else begin
         state      <= next_state;
         cur        <= next_cur;
         cnt        <= next_cnt;
         rdata      <= next_rdata;
         req_done   <= next_done;
         req_onchip <= next_onchip;
      end
   end

   // ----------------------------------------------------------------
   // Pin drivers, registered so every pin comes from a flip-flop
   // ----------------------------------------------------------------
   logic       ext_busy;
   logic       strobe_ph;
   logic [7:0] next_ad_o;
   logic       next_ad_oe;
   logic       next_ale;
   logic       next_program_store_strobe_n_n;
   logic       next_rdpin;
   logic       next_wr_n;
   logic [7:0] next_upper;
   logic       next_a17;
   logic       next_a16;

   assign ext_busy  = (next_state == embus_pkg::EMB_ALE) ||
                      (next_state == embus_pkg::EMB_ADDR_HOLD) ||
                      (next_state == embus_pkg::EMB_STROBE);
   assign strobe_ph = (next_state == embus_pkg::EMB_STROBE);

   always_comb begin
      next_ad_o  = strobe_ph ? next_cur.wdata : next_cur.addr[7:0];
      next_ad_oe = ext_busy && (!strobe_ph || next_cur.is_write);
      next_ale    = (next_state == embus_pkg::EMB_ALE);
      next_upper  = ext_busy ? next_cur.addr[15:8] : upper_address_byte;
      // Bit 17 in 256K mode only
      next_a17    = ext_busy && a17_on && next_cur.addr[17];
      next_a16    = ext_busy && a16_dedicated && next_cur.addr[16];
      // Program strobe over code range
      // With bit 16 on the read pin, the program strobe reads data as well
      next_program_store_strobe_n_n = !(strobe_ph && !next_cur.is_write && (next_cur.is_code || a16_on_rdpin));
      if (a16_on_rdpin) begin
         next_rdpin = ext_busy ? next_cur.addr[16] : 1'b1;
      end else begin
         next_rdpin = !(strobe_ph && !next_cur.is_code && !next_cur.is_write);
      end
      next_wr_n = !(strobe_ph && next_cur.is_write);
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         muxed_addr_data_low_o  <= embus_pkg::DATA_RST;
         muxed_addr_data_low_oe <= 1'b0;
         addr_latch_strobe      <= 1'b0;
         upper_address_byte     <= 8'h00;
         top_address_bit        <= 1'b0;
         second_top_address_bit <= 1'b0;
         program_store_strobe_n <= 1'b1;
         rd_or_a16_pin          <= 1'b1;
         write_strobe_n         <= 1'b1;
      end else begin
         muxed_addr_data_low_o  <= next_ad_o;
         muxed_addr_data_low_oe <= next_ad_oe;
         addr_latch_strobe      <= next_ale;
         upper_address_byte     <= next_upper;
         top_address_bit        <= next_a17;
         second_top_address_bit <= next_a16;
         program_store_strobe_n <= next_program_store_strobe_n_n;
         rd_or_a16_pin          <= next_rdpin;
         write_strobe_n         <= next_wr_n;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_ale_addr;
      @(posedge sys_clk) disable iff (!rst_n)
      addr_latch_strobe |-> muxed_addr_data_low_oe && (muxed_addr_data_low_o == cur.addr[7:0]);
   endproperty
   a_ale_addr: assert property (p_ale_addr) else $error("latch strobe without address");

   property p_ale_then_strobe;
      @(posedge sys_clk) disable iff (!rst_n)
      $fell(addr_latch_strobe) |-> ##1 (!program_store_strobe_n || !write_strobe_n ||
                                       !rd_or_a16_pin || a16_on_rdpin);
   endproperty
   a_ale_then_strobe: assert property (p_ale_then_strobe) else $error("no strobe after latch");

   property p_upper;
      @(posedge sys_clk) disable iff (!rst_n)
      addr_latch_strobe |-> upper_address_byte == cur.addr[15:8];
   endproperty
   a_upper: assert property (p_upper) else $error("upper byte wrong");

   property p_a17;
      @(posedge sys_clk) disable iff (!rst_n)
      !a17_on |-> !top_address_bit;
   endproperty
   a_a17: assert property (p_a17) else $error("bit 17 driven outside 256K");

   property p_a16;
      @(posedge sys_clk) disable iff (!rst_n)
      addr_latch_strobe && a16_dedicated |-> second_top_address_bit == cur.addr[16];
   endproperty
   a_a16: assert property (p_a16) else $error("bit 16 wrong");

   property p_wait;
      @(posedge sys_clk) disable iff (!rst_n)
      (state == embus_pkg::EMB_STROBE) && wait_low |=> (state == embus_pkg::EMB_STROBE);
   endproperty
   a_wait: assert property (p_wait) else $error("cycle ended during wait");

   property p_strap_hold;
      @(posedge sys_clk) disable iff (!rst_n)
      $past(strap_taken) |-> $stable(strap_hi);
   endproperty
   a_strap_hold: assert property (p_strap_hold) else $error("strap changed after reset");

   property p_offchip_low;
      @(posedge sys_clk) disable iff (!rst_n)
      !strap_hi |-> !req_onchip;
   endproperty
   a_offchip_low: assert property (p_offchip_low) else $error("on-chip fetch with strap low");

   property p_onchip;
      @(posedge sys_clk) disable iff (!rst_n)
      (state == embus_pkg::EMB_IDLE) && req_valid && strap_taken && onchip_hit
         |=> req_onchip && req_done && !addr_latch_strobe;
   endproperty
   a_onchip: assert property (p_onchip) else $error("on-chip fetch went out");

   property p_program_store_strobe_n;
      @(posedge sys_clk) disable iff (!rst_n)
      !program_store_strobe_n |-> !cur.is_write && (cur.is_code || a16_on_rdpin);
   endproperty
   a_program_store_strobe_n: assert property (p_program_store_strobe_n) else $error("program strobe on data");

   c_ext_read:  cover property (@(posedge sys_clk) disable iff (!rst_n)
                   !rd_or_a16_pin && !a16_on_rdpin ##1 req_done);
   c_ext_fetch: cover property (@(posedge sys_clk) disable iff (!rst_n)
                   !program_store_strobe_n ##1 req_done);
   c_waited:    cover property (@(posedge sys_clk) disable iff (!rst_n)
                   (state == embus_pkg::EMB_STROBE) [*3] ##1 req_done);
   c_onchip:    cover property (@(posedge sys_clk) disable iff (!rst_n) req_onchip);

endmodule

// file: test/embus_mem_model.sv
/*
  External code/data memory with an address latch, far side of the bus.
  Assumes the bench resolves the shared byte and feeds it back as ad.
*/
module embus_mem_model (
   input  wire logic       sys_clk,
   input  wire logic [1:0] range_cfg,
   input  wire logic [7:0] ad,
   input  wire logic [7:0] upper_address_byte,
   input  wire logic       top_address_bit,
   input  wire logic       second_top_address_bit,
   input  wire logic       rd_or_a16_pin,
   input  wire logic       write_strobe_n,
   input  wire logic       program_store_strobe_n,
   input  wire logic       addr_latch_strobe,
   input  wire integer     wait_len,
   output logic            mem_oe,
   output logic [7:0]      mem_d,
   output logic            async_wait_n,
   output logic [17:0]     last_addr,
   output int              cyc_cnt
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [logic [17:0]];
   int         wcnt = 0;
   initial cyc_cnt = 0;
   // ------------------------------------------------------------
   // Latch and strobes
   // ------------------------------------------------------------
   // latch on strobe fall
   always @(negedge addr_latch_strobe) begin
      last_addr = {top_address_bit,
                   range_cfg == embus_pkg::RANGE_128K_RDPIN ? rd_or_a16_pin
                                                            : second_top_address_bit,
                   upper_address_byte, ad};
      cyc_cnt++;
   end
   // Unwritten cells give an address pattern, never a stale byte
   always @(posedge sys_clk) begin
      mem_d <= mem.exists(last_addr) ? mem[last_addr] : last_addr[7:0] ^ 8'hA5;
      if (!write_strobe_n) mem[last_addr] = ad;
   end
   assign mem_oe = !program_store_strobe_n ||
                   (range_cfg != embus_pkg::RANGE_128K_RDPIN && !rd_or_a16_pin);
   always @(posedge sys_clk) begin
      if (addr_latch_strobe) wcnt <= wait_len;
      else if (wcnt > 0) wcnt <= wcnt - 1;
   end
   // Wait goes low with the latch strobe, early enough for the synchroniser
   assign async_wait_n = (wcnt == 0) && !(addr_latch_strobe && wait_len > 0);
endmodule

// file: test/external_memory_bus_tb.sv
/*
  Bench for the external memory bus controller: writes, reads and code
  fetches in every range mode, strap at both levels, wait stretching.
  Assumes embus_pkg and the memory model are compiled before it.
*/
module external_memory_bus_tb;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {
      logic [7:0]  rd;
      logic        is_rd;
      logic        onchip;
      logic [17:0] addr;
   } embus_exp_s;
   logic                  sys_clk = 1'b0;
   logic                  rst_n = 1'b0;
   logic [1:0]            range_cfg = 2'h0;
   logic                  req_valid = 1'b0;
   logic                  strap_n = 1'b0;
   logic                  strap_at_rst = 1'b0;
   embus_pkg::embus_req_s req = '0;
   logic                  req_done, req_onchip, ad_oe, mem_oe, wait_n, program_store_strobe_n_n;
   logic                  a17, a16, rd_pin, wr_n, ale;
   logic [7:0]            rdata, ad_o, mem_d, upper, ad_last = 8'h00;
   logic [17:0]           m_addr;
   int                    m_cyc, wait_len = 0, error_cnt = 0, n_checks = 0, prev_cyc = 0;
   logic [7:0]            shadow [logic [17:0]];
   embus_exp_s            exp_q [$];
   // Released bus shows a changing pattern, as nobody holds it
   wire [7:0] ad = ad_oe ? ad_o : mem_oe ? mem_d : ~ad_last;
   always @(posedge sys_clk) ad_last <= ad;
   always #25 sys_clk = ~sys_clk;

   embus_ctrl u_embus_ctrl (
      .sys_clk(sys_clk), .rst_n(rst_n), .range_cfg(range_cfg), .req_valid(req_valid),
      .req(req), .req_done(req_done), .req_onchip(req_onchip), .rdata(rdata),
      .muxed_addr_data_low_o(ad_o), .muxed_addr_data_low_oe(ad_oe),
      .muxed_addr_data_low_i(ad), .upper_address_byte(upper), .top_address_bit(a17),
      .second_top_address_bit(a16), .rd_or_a16_pin(rd_pin), .write_strobe_n(wr_n),
      .program_store_strobe_n(program_store_strobe_n_n), .addr_latch_strobe(ale),
      .async_wait_n(wait_n), .external_access_select_n(strap_n));

   embus_mem_model u_embus_mem_model (
      .sys_clk(sys_clk), .range_cfg(range_cfg), .ad(ad), .upper_address_byte(upper),
      .top_address_bit(a17), .second_top_address_bit(a16), .rd_or_a16_pin(rd_pin),
      .write_strobe_n(wr_n), .program_store_strobe_n(program_store_strobe_n_n), .addr_latch_strobe(ale),
      .wait_len(wait_len), .mem_oe(mem_oe), .mem_d(mem_d), .async_wait_n(wait_n),
      .last_addr(m_addr), .cyc_cnt(m_cyc));

   // ------------------------------------------------------------
   // Compare and drive tasks
   // ------------------------------------------------------------
   task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
      n_checks++;
      if (exp !== got) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_lat(input int lo, input int hi, input int got);
      n_checks++;
      if (got < lo || got > hi) begin
         error_cnt++;
         $display("[ERR] latency expected %0d..%0d seen %0d", lo, hi, got);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic do_reset(input logic [1:0] m, input logic s);
      @(posedge sys_clk);
      rst_n <= 1'b0;
      range_cfg <= m;
      strap_n <= s;
      strap_at_rst = s;
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      prev_cyc = m_cyc;
   endtask

   task automatic access(input logic code, input logic wr, input logic [17:0] a,
                         input logic [7:0] d);
      embus_exp_s e;
      int lat;
      // Pins that a mode leaves unused must read as zero
      e.addr = range_cfg == embus_pkg::RANGE_256K ? a :
               range_cfg == embus_pkg::RANGE_64K ? {2'h0, a[15:0]} : {1'h0, a[16:0]};
      e.onchip = code && strap_at_rst && a <= embus_pkg::ROM_TOP_RST;
      e.is_rd = !wr;
      if (wr) shadow[e.addr] = d;
      e.rd = shadow.exists(e.addr) ? shadow[e.addr] : e.addr[7:0] ^ 8'hA5;
      exp_q.push_back(e);
      lat = 0;
      @(posedge sys_clk);
      req_valid <= 1'b1;
      req <= '{is_code: code, is_write: wr, addr: a, wdata: d};
      do begin
         @(posedge sys_clk);
         lat++;
      end while (req_done !== 1'b1 && lat < 100);
      req_valid <= 1'b0;
      if (wait_len > 0) chk_lat(wait_len + 5, wait_len + 7, lat);
      else chk_lat(e.onchip ? 2 : 5, e.onchip ? 2 : 5, lat);
      repeat (2) @(posedge sys_clk);
   endtask

   always @(posedge sys_clk) begin : mon
      embus_exp_s e;
      if (req_done === 1'b1) begin
         if (exp_q.size() == 0) begin
            error_cnt++;
            $display("[ERR] done expected none seen 1");
         end else begin
            e = exp_q.pop_front();
            chk("onchip", 18'(e.onchip), 18'(req_onchip));
            chk("cycles", 18'(prev_cyc + (e.onchip ? 0 : 1)), 18'(m_cyc));
            if (!e.onchip) chk("address", e.addr, m_addr);
            if (e.is_rd && !e.onchip) chk("rdata", 18'(e.rd), 18'(rdata));
            prev_cyc = m_cyc;
         end
      end
   end

   initial begin : main
      logic [17:0] a;
      void'($urandom(3429));
      for (int m = 0; m < 4; m++) begin
         do_reset(2'(m), 1'b0);
         repeat (3) begin
            a = 18'($urandom);
            access(1'b0, 1'b1, a, 8'($urandom));
            access(1'b0, 1'b0, a, 8'h00);
            access(1'b1, 1'b0, a & 18'h07FFF, 8'h00);
         end
         $display("test range mode %0d done", m);
      end
      do_reset(embus_pkg::RANGE_256K, 1'b1);
      access(1'b1, 1'b0, 18'h00000, 8'h00);
      access(1'b1, 1'b0, embus_pkg::ROM_TOP_RST, 8'h00);
      access(1'b1, 1'b0, embus_pkg::ROM_TOP_RST + 18'h1, 8'h00);
      access(1'b0, 1'b0, 18'h00010, 8'h00);
      strap_n <= 1'b0;
      access(1'b1, 1'b0, 18'h00020, 8'h00);
      $display("test strap done");
      wait_len = 6;
      access(1'b0, 1'b1, 18'h2A5C3, 8'h3C);
      access(1'b1, 1'b0, 18'h2A5C3, 8'h00);
      wait_len = 0;
      $display("test wait done");
      report_and_stop();
   end

   initial begin : watchdog
      repeat (20000) @(posedge sys_clk);
      error_cnt++;
      $display("[ERR] watchdog expected finish seen hang");
      report_and_stop();
   end
endmodule
